// ===== rtl/deadband_channel.sv
/*
 * One dead-band channel: splits a phase waveform into a high-side and
 * low-side pair that cannot overlap while enabled; disabled, both copy it.
 * Assumes its own prescale tick and a shared period value from the parent.
 */
`timescale 1ns/1ps
module deadband_channel
    import pwm_deadband_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic tick,
    input wire logic [3:0] period,
    input wire logic phase_in,
    output logic phase_high,
    output logic phase_low
);

    db_state_type state_r;
    logic [3:0] count_r;
    logic target_r;

    // Target side follows the phase; the new side turns on only after
    // the delay has elapsed with both sides off.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= DB_BOTH_OFF;
            count_r <= 4'h0;
            target_r <= 1'b0;
        end else if (!enable) begin
            state_r <= DB_ON;
            count_r <= 4'h0;
            target_r <= phase_in;
        end else begin
            unique case (state_r)
                DB_BOTH_OFF: begin
                    target_r <= phase_in;
                    count_r <= period;
                    state_r <= DB_WAIT;
                end
                DB_WAIT: begin
                    if (phase_in != target_r) begin
                        target_r <= phase_in;
                        count_r <= period;
                    end else if (count_r == 4'h0) begin
                        state_r <= DB_ON;
                    end else if (tick) begin
                        count_r <= count_r - 4'h1;
                    end
                end
                DB_ON: begin
                    if (phase_in != target_r) begin
                        target_r <= phase_in;
                        count_r <= period;
                        state_r <= DB_WAIT;
                    end
                end
                default: begin
                    state_r <= DB_BOTH_OFF;
                end
            endcase
        end
    end

    // Both sides low while waiting, so an enabled pair can never overlap
    always_comb begin
        if (!enable) begin
            phase_high = phase_in;
            phase_low = phase_in;
        end else begin
            phase_high = (state_r == DB_ON) && target_r;
            phase_low = (state_r == DB_ON) && !target_r;
        end
    end

endmodule : deadband_channel

// ===== rtl/pwm_deadband_output_logic.sv
/*
 * PWM output stage: timer 1, three compare units, dead-band, output
 * polarity/forcing and high-impedance control of six pins.
 * Assumes a simple register port (write strobe, read strobe, data one
 * cycle later) and an active-low protect input synchronous to clk.
 */
// What this block does
// - With dead-band enabled and active-high actions, upper and lower outputs of a pair never both on.
// - Non-overlap holds for dead-band above duty and at 0% or 100% duty.
// - With dead-band enabled, pair is not forced inactive at period end.
// - Each pin selects active low, active high, forced low or forced high.
// - Output logic sets each of the six pin levels on compare match.
// - Clearing compare-control bits 9 and 8 tri-states all six pins.
// - Protect input low while unmasked tri-states all six pins.
// - Any reset puts all six pins in high impedance.
// - Protect fault and reset override compare and action settings.
// - Output logic uses dead-band pair, match, action bits, fault, reset.
// - Compare value matched against timer continuously toggles output.
// - Period end gives the opposite transition.
// - Timer period is carrier period; one pulse per period.
// - Three compare units on timer 1 give three pairs, complementary when dead-band is enabled.
// - Dead-band length is period value times prescale divisor in clocks.
// - Prescale codes 0..5 divide by 1..32; higher codes divide by 32.
// - Dead-band disabled: both outputs copy the phase input.
`timescale 1ns/1ps
module pwm_deadband_output_logic
    import pwm_deadband_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic power_drive_protect_n,
    output logic [5:0] pwm_output_pin,
    output logic [5:0] pwm_output_oe
);

    logic [15:0] compare_action_control_r;
    logic [15:0] deadband_timer_control_r;
    logic [15:0] compare_value_reg_r [3];
    logic [15:0] compare_shadow_r [3];
    logic [15:0] compare_control_reg_r;
    logic [15:0] timer1_control_reg_r;
    logic [15:0] timer1_period_r;
    logic [15:0] timer1_count_r;
    logic fault_mask_r;
    logic fault_latch_r;
    logic [2:0] waveform_phase_in_r;
    logic [4:0] prescale_count_r [3];
    logic [4:0] prescale_limit;
    logic [2:0] prescale_tick;
    logic [2:0] phase_seen_r;
    logic timer_run;
    logic period_end;
    logic [2:0] compare_match;
    logic [2:0] deadband_phase_high;
    logic [2:0] deadband_phase_low;
    logic [5:0] pair_level;
    logic outputs_enabled;
    logic [15:0] rdata_nxt;

    assign timer_run = timer1_control_reg_r[T1_RUN_BIT];
    assign period_end = timer_run && (timer1_count_r == timer1_period_r);

    // Register writes; compare values go to a shadow loaded at period end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_action_control_r <= RESET_ZERO;
            deadband_timer_control_r <= RESET_ZERO;
            compare_control_reg_r <= RESET_ZERO;
            timer1_control_reg_r <= RESET_ZERO;
            timer1_period_r <= RESET_PERIOD;
            fault_mask_r <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                compare_value_reg_r[i] <= RESET_ZERO;
            end
        end else if (reg_wr) begin
            unique case (reg_addr)
                ADDR_ACTION: compare_action_control_r <= reg_wdata & ACT_WRITE_MASK;
                ADDR_DEADBAND: deadband_timer_control_r <= reg_wdata & DB_WRITE_MASK;
                ADDR_CMP1: compare_value_reg_r[0] <= reg_wdata;
                ADDR_CMP2: compare_value_reg_r[1] <= reg_wdata;
                ADDR_CMP3: compare_value_reg_r[2] <= reg_wdata;
                ADDR_COMPARE_CTL: compare_control_reg_r <= reg_wdata & CC_WRITE_MASK;
                ADDR_TIMER1_CTL: timer1_control_reg_r <= reg_wdata & T1_WRITE_MASK;
                ADDR_TIMER1_PERIOD: timer1_period_r <= reg_wdata;
                ADDR_STATUS: fault_mask_r <= reg_wdata[ST_FAULT_MASK_BIT];
                default: begin
                end
            endcase
        end
    end

    // Timer 1 counts up and wraps at the period: one carrier period
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer1_count_r <= RESET_ZERO;
        end else if (!timer_run) begin
            timer1_count_r <= RESET_ZERO;
        end else if (period_end) begin
            timer1_count_r <= RESET_ZERO;
        end else begin
            timer1_count_r <= timer1_count_r + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 3; i++) begin
                compare_shadow_r[i] <= RESET_ZERO;
            end
        end else if (!timer_run || period_end) begin
            for (int i = 0; i < 3; i++) begin
                compare_shadow_r[i] <= compare_value_reg_r[i];
            end
        end
    end

    // Phase goes high on match and low at period end: one pulse a period
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            compare_match[i] = timer_run && compare_control_reg_r[CC_COMPARE_EN_BIT] &&
                (timer1_count_r == compare_shadow_r[i]);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waveform_phase_in_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (period_end || !compare_control_reg_r[CC_COMPARE_EN_BIT]) begin
                    waveform_phase_in_r[i] <= 1'b0;
                end else if (compare_match[i]) begin
                    waveform_phase_in_r[i] <= 1'b1;
                end
            end
        end
    end

    // Dead-band prescaler; codes above five clamp to divide by 32
    always_comb begin
        logic [2:0] code;
        code = deadband_timer_control_r[DB_PRESCALE_LSB +: 3];
        if (code > 3'(PRESCALE_MAX_CODE)) begin
            prescale_limit = 5'h1f;
        end else begin
            prescale_limit = 5'((6'h01 << code) - 6'h01);
        end
    end

    // One prescaler per channel, restarted on its phase change, so the
    // wait never falls short of period times divisor
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_seen_r <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                prescale_count_r[i] <= 5'h00;
            end
        end else begin
            phase_seen_r <= waveform_phase_in_r;
            for (int i = 0; i < 3; i++) begin
                if (waveform_phase_in_r[i] != phase_seen_r[i]) begin
                    prescale_count_r[i] <= 5'h00;
                end else if (prescale_count_r[i] >= prescale_limit) begin
                    prescale_count_r[i] <= 5'h00;
                end else begin
                    prescale_count_r[i] <= prescale_count_r[i] + 5'h01;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            prescale_tick[i] = (prescale_count_r[i] >= prescale_limit);
        end
    end

    // Three dead-band channels; enabled channels never reset at period end
    for (genvar g = 0; g < 3; g++) begin : g_deadband
        deadband_channel u_channel (
            .clk(clk),
            .rst_b(rst_b),
            .enable(deadband_timer_control_r[DB_ENABLE_LSB + g]),
            .tick(prescale_tick[g]),
            .period(deadband_timer_control_r[DB_PERIOD_LSB +: 4]),
            .phase_in(waveform_phase_in_r[g]),
            .phase_high(deadband_phase_high[g]),
            .phase_low(deadband_phase_low[g])
        );
    end

    // Fault latch: protect low while unmasked; set wins over clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_latch_r <= 1'b0;
        end else if (fault_mask_r && !power_drive_protect_n) begin
            fault_latch_r <= 1'b1;
        end else if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[ST_FAULT_LATCH_BIT]) begin
            fault_latch_r <= 1'b0;
        end
    end

    assign outputs_enabled = compare_control_reg_r[CC_OUT_EN_HI_BIT] &&
        compare_control_reg_r[CC_OUT_EN_LO_BIT] && !fault_latch_r &&
        !(fault_mask_r && !power_drive_protect_n);

    // Action per pin applied to the dead-band pair
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pair_level[2 * i] = deadband_phase_high[i];
            pair_level[2 * i + 1] = deadband_phase_low[i];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_output_pin <= 6'h00;
            pwm_output_oe <= 6'h00;
        end else begin
            for (int p = 0; p < 6; p++) begin
                pwm_output_oe[p] <= outputs_enabled;
                unique case (action_type'(compare_action_control_r[ACT_W * p +: ACT_W]))
                    ACT_FORCE_LOW: pwm_output_pin[p] <= 1'b0;
                    ACT_ACTIVE_LOW: pwm_output_pin[p] <= !pair_level[p];
                    ACT_ACTIVE_HIGH: pwm_output_pin[p] <= pair_level[p];
                    ACT_FORCE_HIGH: pwm_output_pin[p] <= 1'b1;
                endcase
            end
        end
    end

    // Read path, data one cycle after the strobe
    always_comb begin
        unique case (reg_addr)
            ADDR_ACTION: rdata_nxt = compare_action_control_r;
            ADDR_DEADBAND: rdata_nxt = deadband_timer_control_r;
            ADDR_CMP1: rdata_nxt = compare_value_reg_r[0];
            ADDR_CMP2: rdata_nxt = compare_value_reg_r[1];
            ADDR_CMP3: rdata_nxt = compare_value_reg_r[2];
            ADDR_COMPARE_CTL: rdata_nxt = compare_control_reg_r;
            ADDR_TIMER1_CTL: rdata_nxt = timer1_control_reg_r;
            ADDR_TIMER1_PERIOD: rdata_nxt = timer1_period_r;
            ADDR_STATUS: rdata_nxt = {13'h0000, !power_drive_protect_n, fault_latch_r, fault_mask_r};
            default: rdata_nxt = RESET_ZERO;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= RESET_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= RESET_ZERO;
        end
    end

endmodule : pwm_deadband_output_logic

// ===== rtl/pwm_deadband_pkg.sv
/*
 * Constants for the three-phase PWM output stage: register map, field
 * positions, reset values and action-control codes.
 * Assumes a 16-bit register port with one-cycle read latency.
 */
package pwm_deadband_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 4;

    // Register offsets (word addresses on the plain port)
    localparam logic [3:0] ADDR_ACTION = 4'h0;
    localparam logic [3:0] ADDR_DEADBAND = 4'h1;
    localparam logic [3:0] ADDR_CMP1 = 4'h2;
    localparam logic [3:0] ADDR_CMP2 = 4'h3;
    localparam logic [3:0] ADDR_CMP3 = 4'h4;
    localparam logic [3:0] ADDR_COMPARE_CTL = 4'h5;
    localparam logic [3:0] ADDR_TIMER1_CTL = 4'h6;
    localparam logic [3:0] ADDR_TIMER1_PERIOD = 4'h7;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // Dead-band control fields
    localparam int unsigned DB_PERIOD_LSB = 8;
    localparam int unsigned DB_ENABLE_LSB = 5;
    localparam int unsigned DB_PRESCALE_LSB = 2;
    localparam logic [15:0] DB_WRITE_MASK = 16'h0ffc;

    // Compare control fields
    localparam int unsigned CC_COMPARE_EN_BIT = 15;
    localparam int unsigned CC_OUT_EN_HI_BIT = 9;
    localparam int unsigned CC_OUT_EN_LO_BIT = 8;
    localparam logic [15:0] CC_WRITE_MASK = 16'h8300;

    // Timer 1 control fields
    localparam int unsigned T1_RUN_BIT = 6;
    localparam logic [15:0] T1_WRITE_MASK = 16'h0040;

    // Action-control field: two bits per pin, pin 1 in bits 1:0
    localparam int unsigned ACT_W = 2;
    localparam logic [15:0] ACT_WRITE_MASK = 16'h0fff;

    // Status fields
    localparam int unsigned ST_FAULT_MASK_BIT = 0;
    localparam int unsigned ST_FAULT_LATCH_BIT = 1;

    localparam logic [15:0] RESET_ZERO = 16'h0000;
    localparam logic [15:0] RESET_PERIOD = 16'hffff;
    localparam int unsigned PRESCALE_MAX_CODE = 5;

    typedef enum logic [1:0] {
        ACT_FORCE_LOW = 2'h0,
        ACT_ACTIVE_LOW = 2'h1,
        ACT_ACTIVE_HIGH = 2'h2,
        ACT_FORCE_HIGH = 2'h3
    } action_type;

    typedef enum logic [2:0] {
        DB_BOTH_OFF = 3'h1,
        DB_WAIT = 3'h2,
        DB_ON = 3'h4
    } db_state_type;

endpackage : pwm_deadband_pkg

// ===== test/gate_driver_model.sv
/* Gate-driver model of the inverter bridge: resolves pins to gate levels and
   flags any leg with both switches on. Assumes active-high gate inputs. */
`timescale 1ns/1ps
module gate_driver_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] pwm_output_pin,
    input wire logic [5:0] pwm_output_oe,
    output logic [5:0] gate_level,
    output logic [2:0] shoot_through
);
    // Pull-down holds a floating gate off
    assign gate_level = pwm_output_pin & pwm_output_oe;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shoot_through <= 3'h0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                shoot_through[k] <= shoot_through[k] | (gate_level[2*k] & gate_level[2*k+1]);
            end
        end
    end
endmodule : gate_driver_model

// ===== test/pwm_deadband_output_logic_sva.sv
/* Checker for the PWM output stage: enables, forcing, pair overlap, dead gap.
   Sees only the top-level ports; bound to the design at the foot. */
`timescale 1ns/1ps
module pwm_deadband_output_logic_sva
    import pwm_deadband_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic power_drive_protect_n,
    input wire logic [5:0] pwm_output_pin,
    input wire logic [5:0] pwm_output_oe
);
    logic [11:0] act_r;
    logic [11:0] db_r;
    logic mask_r;
    logic [9:0] age_r;
    logic [9:0] gap_r;
    logic [9:0] db_len;
    logic both_off;
    logic bad_force;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Shadow of the setup written on the bus
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            act_r <= 12'h000;
            db_r <= 12'h000;
            mask_r <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_ACTION: act_r <= reg_wdata[11:0];
                ADDR_DEADBAND: db_r <= reg_wdata[11:0];
                ADDR_STATUS: mask_r <= reg_wdata[0];
                default: ;
            endcase
        end
    end
    // Settling age and length of the both-off gap on pair one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            age_r <= 10'h000;
            gap_r <= 10'h000;
        end else begin
            age_r <= (reg_wr && reg_addr inside {ADDR_ACTION, ADDR_DEADBAND, ADDR_COMPARE_CTL}) ? 10'h000
                : age_r + {9'h0, age_r != 10'h3ff};
            gap_r <= both_off ? gap_r + {9'h0, gap_r != 10'h3ff} : 10'h000;
        end
    end
    assign both_off = !pwm_output_pin[0] && !pwm_output_pin[1];
    assign db_len = {6'h0, db_r[11:8]} << ((db_r[4:2] > 3'h5) ? 3'h5 : db_r[4:2]);
    always_comb begin
        bad_force = 1'b0;
        for (int i = 0; i < 6; i++) begin
            bad_force |= (act_r[2*i +: 2] == ACT_FORCE_LOW && pwm_output_pin[i])
                || (act_r[2*i +: 2] == ACT_FORCE_HIGH && !pwm_output_pin[i]);
        end
    end
    AST_NO_OVERLAP: assert property (age_r > 10'd4 && db_r[5] && act_r[3:0] == 4'ha
        |-> !(pwm_output_pin[0] && pwm_output_pin[1])) else $error("pair one both on");
    AST_DEAD_GAP: assert property (age_r > gap_r + 10'd4 && db_r[5] && act_r[3:0] == 4'ha
        && $fell(both_off) |-> gap_r >= db_len) else $error("dead gap too short");
    AST_OE_SAME: assert property (pwm_output_oe == 6'h00 || pwm_output_oe == 6'h3f)
        else $error("enables differ");
    AST_OE_CLEAR: assert property (reg_wr && reg_addr == ADDR_COMPARE_CTL && reg_wdata[9:8] != 2'h3
        |-> ##2 pwm_output_oe == 6'h00) else $error("pins not released");
    AST_FAULT_OFF: assert property (mask_r && !power_drive_protect_n |=> pwm_output_oe == 6'h00)
        else $error("fault did not release pins");
    AST_FAULT_HOLD: assert property ($rose(pwm_output_oe[0]) |-> !mask_r || $past(power_drive_protect_n))
        else $error("pins enabled during fault");
    AST_FORCED: assert property (age_r > 10'd4 && pwm_output_oe[0] |-> !bad_force)
        else $error("forced level wrong");
    AST_DB_OFF_COPY: assert property (age_r > 10'd4 && !db_r[6] && act_r[7:4] == 4'ha
        |-> pwm_output_pin[2] == pwm_output_pin[3]) else $error("pair two not a copy");
    AST_RESET_OFF: assert property (!$past(rst_b) |-> pwm_output_oe == 6'h00)
        else $error("pins driven after reset");
    cover property (mask_r && !power_drive_protect_n);
    cover property (db_r[5] && $fell(both_off) && gap_r > 10'd20);
    cover property ($rose(pwm_output_oe[0]));
endmodule : pwm_deadband_output_logic_sva

bind pwm_deadband_output_logic pwm_deadband_output_logic_sva i_sva (.clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .power_drive_protect_n, .pwm_output_pin, .pwm_output_oe);

// ===== test/test_pwm_deadband_output_logic.sv
/* Self-checking bench for the PWM output stage with a gate-driver partner.
   Assumes the checker is bound to the design from its own file. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin failures++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_pwm_deadband_output_logic
    import pwm_deadband_pkg::*;
;
    localparam int PER = 199;
    logic clk = 1'b0;
    logic rst_b;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic prot_n;
    logic [5:0] pin;
    logic [5:0] oe;
    logic [5:0] gate;
    logic [2:0] shoot;
    logic [31:0] seed;
    logic [15:0] c2;
    int failures = 0;
    int checks = 0;
    logic [31:0] hi;
    logic [31:0] rises;

    always #50 clk = ~clk;

    pwm_deadband_output_logic i_dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .power_drive_protect_n(prot_n), .pwm_output_pin(pin), .pwm_output_oe(oe));
    gate_driver_model i_gate (.clk, .rst_b, .pwm_output_pin(pin), .pwm_output_oe(oe), .gate_level(gate),
        .shoot_through(shoot));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    // All phases low: dead-band pairs rest on the low side
    function automatic logic [5:0] exp_pins(input logic [1:0] c);
        return (c == 2'h0) ? 6'h00 : (c == 2'h3) ? 6'h3f : (c == 2'h2) ? 6'h22 : 6'h1d;
    endfunction : exp_pins
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("rdata", e, reg_rdata)
    endtask : rd
    task automatic meas(input int idx, output logic [31:0] h, output logic [31:0] r);
        logic p;
        h = 32'h0;
        r = 32'h0;
        p = pin[idx];
        repeat (PER + 1) begin
            @(posedge clk);
            #1;
            h += {31'h0, pin[idx]};
            r += {31'h0, pin[idx] && !p};
            p = pin[idx];
            `CHK("copy", pin[2], pin[3])
        end
    endtask : meas
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    initial begin
        #2000000;
        failures++;
        close_out();
    end

    initial begin
        rst_b <= 1'b0;
        reg_addr <= 4'h0;
        reg_wdata <= 16'h0000;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        prot_n <= 1'b1;
        seed = 32'h0ee7;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        `CHK("oe reset", 6'h00, oe)
        rd(ADDR_TIMER1_PERIOD, 16'hffff);
        rd(ADDR_ACTION, 16'h0000);
        rd(4'hf, 16'h0000);
        wr(ADDR_ACTION, 16'h0aaa);
        wr(ADDR_DEADBAND, 16'h0fbc);
        wr(ADDR_CMP1, 16'h0000);
        wr(ADDR_CMP2, 16'h0fff);
        wr(ADDR_CMP3, 16'h0fff);
        wr(ADDR_TIMER1_PERIOD, 16'(PER));
        wr(ADDR_COMPARE_CTL, 16'h8300);
        wr(ADDR_TIMER1_CTL, 16'h0040);
        cyc(2 * PER + 500);
        meas(5, hi, rises);
        `CHK("low side held", PER + 1, hi)
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            c2 = 16'h0001 + 16'(seed[15:0] % (PER - 1));
            wr(ADDR_DEADBAND, {4'h0, seed[27:24], 3'h5, seed[30:28], 2'h0});
            wr(ADDR_CMP1, {8'h00, seed[23:16]});
            wr(ADDR_CMP2, c2);
            wr(ADDR_CMP3, {8'h00, seed[7:0]});
            cyc(PER + 4);
            meas(2, hi, rises);
            `CHK("width", PER - int'(c2), hi)
            `CHK("pulses", 1, rises)
        end
        // Pair two runs without dead-band, so its copies overlap by design
        `CHK("overlap", 3'h2, shoot)
        for (int k = 0; k < 3; k++) wr(ADDR_CMP1 + 4'(k), 16'h0fff);
        cyc(PER + 500);
        for (int a = 0; a < 4; a++) begin
            wr(ADDR_ACTION, {4'h0, {6{2'(a)}}});
            cyc(4);
            `CHK("gate", exp_pins(2'(a)), gate)
        end
        wr(ADDR_ACTION, 16'h0aaa);
        wr(ADDR_COMPARE_CTL, 16'h8200);
        cyc(2);
        `CHK("oe off", 6'h00, oe)
        wr(ADDR_COMPARE_CTL, 16'h8300);
        cyc(2);
        `CHK("oe on", 6'h3f, oe)
        wr(ADDR_STATUS, 16'h0001);
        prot_n <= 1'b0;
        cyc(2);
        `CHK("oe fault", 6'h00, oe)
        @(posedge clk);
        prot_n <= 1'b1;
        cyc(3);
        `CHK("oe latched", 6'h00, oe)
        wr(ADDR_STATUS, 16'h0003);
        cyc(3);
        `CHK("oe cleared", 6'h3f, oe)
        wr(ADDR_STATUS, 16'h0000);
        prot_n <= 1'b0;
        cyc(3);
        `CHK("oe masked", 6'h3f, oe)
        @(posedge clk);
        prot_n <= 1'b1;
        #30;
        rst_b <= 1'b0;
        #1;
        `CHK("oe in reset", 6'h00, oe)
        close_out();
    end
endmodule : test_pwm_deadband_output_logic
